// >>> hdl/itd_pkg.sv
package itd_pkg;
    // Cycle counts at zero wait states
    localparam logic [5:0] CYC_ONE = 6'h01;
    localparam logic [5:0] CYC_LDST = 6'h02;
    localparam logic [5:0] CYC_FLOW = 6'h03;
    localparam logic [5:0] CYC_FOUR = 6'h04;
    localparam logic [5:0] CYC_HINT = 6'h02;
    localparam logic [5:0] CYC_MUL_SLOW = 6'h20;
    localparam logic [5:0] CYC_POP_PC_BASE = 6'h04;
    localparam logic [5:0] CYC_SVC = 6'h04;
    localparam logic [5:0] CYC_BREAKPOINT_OP = 6'h04;
    localparam logic [5:0] CYC_FAULT = 6'h01;

    typedef enum logic [1:0] {
        ITD_IDLE = 2'h0,
        ITD_EXEC = 2'h1,
        ITD_SLEEP = 2'h3
    } itd_state_t;

    typedef enum logic [3:0] {
        CLS_SINGLE = 4'h0,
        CLS_PC_WRITE = 4'h1,
        CLS_MUL = 4'h2,
        CLS_LDST = 4'h3,
        CLS_MULTI = 4'h4,
        CLS_POP_PC = 4'h5,
        CLS_BCOND = 4'h6,
        CLS_BRANCH = 4'h7,
        CLS_BL = 4'h8,
        CLS_SPECIAL = 4'h9,
        CLS_BARRIER = 4'hA,
        CLS_WAIT = 4'hB,
        CLS_SVC = 4'hC,
        CLS_BREAKPOINT_OP = 4'hD,
        CLS_UNDEF = 4'hE
    } itd_class_t;

    typedef struct packed {
        logic [15:0] hw0;
        logic [15:0] hw1;
        logic cond_pass;
    } itd_instr_t;

    typedef struct packed {
        itd_class_t cls;
        logic [5:0] cycles;
        logic wide;
    } itd_dec_t;
endpackage

// >>> hdl/itd_decode.sv
`timescale 1ns/1ps
module itd_decode
    import itd_pkg::*;
#(
    parameter bit FAST_MUL = 1'b1
) (
    input wire itd_instr_t ins,
    output itd_dec_t dec
);
    logic [15:0] h;
    logic [4:0] nreg;
    always_comb begin
        h = ins.hw0;
        nreg = 5'($countones(h[7:0]));
        dec.cls = CLS_SINGLE;
        dec.cycles = CYC_ONE;
        dec.wide = 1'b0;
        if (h[15:11] == 5'h1D || h[15:11] == 5'h1F || h[15:11] == 5'h1E) begin
            dec.wide = 1'b1;
            dec.cls = CLS_UNDEF;
            dec.cycles = CYC_FAULT;
            if (h[15:11] == 5'h1E && ins.hw1[15:14] == 2'h3 && ins.hw1[12]) begin
                dec.cls = CLS_BL;
                dec.cycles = CYC_FOUR;
            end else if (h[15:4] == 12'hF3B && ins.hw1[15:8] == 8'h8F
                         && ins.hw1[7:4] inside {4'h4, 4'h5, 4'h6}) begin
                dec.cls = CLS_BARRIER;
                dec.cycles = CYC_FOUR;
            end else if ((h[15:5] == 11'h79C || h[15:0] == 16'hF3EF)
                         && ins.hw1[15:14] == 2'h2) begin
                dec.cls = CLS_SPECIAL;
                dec.cycles = CYC_FOUR;
            end
        end else if (h[15:12] == 4'hB && h[10] == 1'b0 && h[8] == 1'b1) begin
            dec.cls = CLS_UNDEF;
            dec.cycles = CYC_FAULT;
        end else if (h[15:8] == 8'hBF && h[3:0] != 4'h0) begin
            dec.cls = CLS_UNDEF;
            dec.cycles = CYC_FAULT;
        end else if (h[15:8] == 8'hBF && (h[7:4] == 4'h2 || h[7:4] == 4'h3)) begin
            dec.cls = CLS_WAIT;
            dec.cycles = CYC_HINT;
        end else if (h[15:8] == 8'hBE) begin
            dec.cls = CLS_BREAKPOINT_OP;
            dec.cycles = CYC_BREAKPOINT_OP;
        end else if (h[15:8] == 8'hDF) begin
            dec.cls = CLS_SVC;
            dec.cycles = CYC_SVC;
        end else if (h[15:12] == 4'hD) begin
            dec.cls = CLS_BCOND;
            dec.cycles = ins.cond_pass ? CYC_FLOW : CYC_ONE;
        end else if (h[15:11] == 5'h1C || h[15:8] == 8'h47) begin
            dec.cls = CLS_BRANCH;
            dec.cycles = CYC_FLOW;
        end else if ((h[15:8] == 8'h44 || h[15:8] == 8'h46) && h[7] && h[2:0] == 3'h7) begin
            dec.cls = CLS_PC_WRITE;
            dec.cycles = CYC_FLOW;
        end else if (h[15:6] == 10'h10D) begin
            dec.cls = CLS_MUL;
            dec.cycles = FAST_MUL ? CYC_ONE : CYC_MUL_SLOW;
        end else if (h[15:9] == 7'h5E && h[8]) begin
            dec.cls = CLS_POP_PC;
            dec.cycles = CYC_POP_PC_BASE + 6'(nreg) + CYC_ONE;
        end else if (h[15:12] == 4'hC || h[15:12] == 4'hB && h[10:9] == 2'h2) begin
            dec.cls = CLS_MULTI;
            dec.cycles = CYC_ONE + 6'(nreg) + 6'(h[15:12] == 4'hB && h[8]);
        end else if (h[15:12] == 4'h5 || h[15:13] == 3'h3 || h[15:12] == 4'h8
                     || h[15:12] == 4'h9 || h[15:11] == 5'h09) begin
            dec.cls = CLS_LDST;
            dec.cycles = CYC_LDST;
        end
    end
endmodule

// >>> hdl/itd_core_timing.sv
`timescale 1ns/1ps
// Operation
// - Accept all compact 16-bit encodings except compare-branch and if-then forms.
// - Wide encodings limited to branch-with-link, three barriers, special register moves.
// - Counts assume zero-wait memory; wait states stretch execution.
// - Data processing, moves, shifts, extends, SP and PC address ops: one cycle, except add or move to PC: three.
// - Multiply takes one or thirty-two cycles by multiplier build.
// - Every single load or store takes two cycles.
// - Multiple loads, stores, push and plain pop take one plus N.
// - Pop including program counter takes four plus N cycles.
// - Conditional branch: three cycles taken, one cycle not taken.
// - Plain and indirect branches three cycles; immediate branch-with-link four.
// - Special register access four cycles; interrupt enable, non-wait hints, nop one.
// - Each barrier takes four cycles.
// - Wait hints take two cycles, excluding suspended time.
// - Supervisor call and breakpoint counts set by configuration.
// - Wait hints then remove core clock until interrupt or wake event.
module itd_core_timing
    import itd_pkg::*;
#(
    parameter bit FAST_MUL = 1'b1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Instruction issue
    input wire logic issue_valid,
    input wire itd_instr_t issue_instr,
    output logic issue_ready_q,
    // Memory wait state
    input wire logic mem_wait,
    // Wake sources
    input wire logic wake_irq,
    // Status
    output logic retire_q,
    output logic [5:0] cycles_q,
    output logic fault_q,
    output logic wide_q,
    output logic core_clk_en_q
);
    itd_dec_t dec;
    itd_state_t state_q;
    logic [5:0] cnt_q;
    logic wait_hint_q;
    logic wake_s1_q;
    logic wake_s2_q;
    logic take;

    itd_decode #(.FAST_MUL(FAST_MUL)) u_dec (
        .ins(issue_instr),
        .dec(dec)
    );

    assign take = issue_valid && issue_ready_q;

    // Wake is asynchronous, so two stages first
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wake_s1_q <= 1'b0;
            wake_s2_q <= 1'b0;
        end else begin
            wake_s1_q <= wake_irq;
            wake_s2_q <= wake_s1_q;
        end
    end

    // Sequencer; cycle count freezes while memory stalls
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= ITD_IDLE;
            cnt_q <= 6'h00;
            wait_hint_q <= 1'b0;
        end else begin
            unique case (state_q)
                ITD_IDLE: begin
                    if (take) begin
                        state_q <= ITD_EXEC;
                        cnt_q <= dec.cycles;
                        wait_hint_q <= (dec.cls == CLS_WAIT);
                    end
                end
                ITD_EXEC: begin
                    if (!mem_wait) begin
                        if (cnt_q == CYC_ONE) begin
                            state_q <= wait_hint_q ? ITD_SLEEP : ITD_IDLE;
                        end
                        cnt_q <= cnt_q - CYC_ONE;
                    end
                end
                ITD_SLEEP: begin
                    if (wake_s2_q) begin
                        state_q <= ITD_IDLE;
                        wait_hint_q <= 1'b0;
                    end
                end
                default: state_q <= ITD_IDLE;
            endcase
        end
    end

    // Handshake and status outputs
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            issue_ready_q <= 1'b1;
            retire_q <= 1'b0;
            cycles_q <= 6'h00;
            fault_q <= 1'b0;
            wide_q <= 1'b0;
        end else begin
            retire_q <= 1'b0;
            if (take) begin
                issue_ready_q <= 1'b0;
                cycles_q <= dec.cycles;
                fault_q <= (dec.cls == CLS_UNDEF);
                wide_q <= dec.wide;
            end else if (state_q == ITD_EXEC && !mem_wait && cnt_q == CYC_ONE) begin
                retire_q <= 1'b1;
                issue_ready_q <= !wait_hint_q;
            end else if (state_q == ITD_SLEEP && wake_s2_q) begin
                issue_ready_q <= 1'b1;
            end
        end
    end

    // Core clock gate: off while suspended
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            core_clk_en_q <= 1'b1;
        end else begin
            core_clk_en_q <= !(state_q == ITD_SLEEP && !wake_s2_q) &&
                !(state_q == ITD_EXEC && wait_hint_q && !mem_wait && cnt_q == CYC_ONE);
        end
    end

    // Elapsed cycles of current instruction, for checking
    logic [5:0] run_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            run_q <= 6'h00;
        end else if (take) begin
            run_q <= 6'h00;
        end else if (state_q == ITD_EXEC) begin
            run_q <= run_q + CYC_ONE;
        end
    end

    property p_retire_count;
        @(posedge clk) disable iff (!nrst)
        (retire_q && !mem_wait) |-> (run_q >= cycles_q);
    endproperty
    a_retire_count: assert property (p_retire_count) else $error("retire before count");

    property p_single;
        @(posedge clk) disable iff (!nrst)
        (take && dec.cls == CLS_SINGLE) ##1 !mem_wait |=> retire_q;
    endproperty
    a_single: assert property (p_single) else $error("single op not one cycle");

    property p_pcw;
        @(posedge clk) disable iff (!nrst)
        (take && dec.cls == CLS_PC_WRITE) ##1 !mem_wait [*3] |=> retire_q;
    endproperty
    a_pcw: assert property (p_pcw) else $error("pc write not three");

    property p_ldst;
        @(posedge clk) disable iff (!nrst)
        (take && dec.cls == CLS_LDST) ##1 !mem_wait [*2] |=> retire_q;
    endproperty
    a_ldst: assert property (p_ldst) else $error("load store not two");

    property p_barrier;
        @(posedge clk) disable iff (!nrst)
        (take && (dec.cls == CLS_BARRIER || dec.cls == CLS_SPECIAL || dec.cls == CLS_BL))
        ##1 !mem_wait [*4] |=> retire_q;
    endproperty
    a_barrier: assert property (p_barrier) else $error("four cycle op wrong");

    property p_bcond;
        @(posedge clk) disable iff (!nrst)
        (take && dec.cls == CLS_BCOND && !issue_instr.cond_pass) |=> (cycles_q == CYC_ONE);
    endproperty
    a_bcond: assert property (p_bcond) else $error("untaken branch not one");

    property p_undef;
        @(posedge clk) disable iff (!nrst)
        (take && dec.cls == CLS_UNDEF) |=> fault_q;
    endproperty
    a_undef: assert property (p_undef) else $error("undefined not faulted");

    property p_sleep;
        @(posedge clk) disable iff (!nrst)
        (state_q == ITD_SLEEP && !wake_s2_q) |=> !core_clk_en_q;
    endproperty
    a_sleep: assert property (p_sleep) else $error("clock not removed");

    property p_wait;
        @(posedge clk) disable iff (!nrst)
        (take && dec.cls == CLS_WAIT) ##1 !mem_wait [*2]
        |=> (retire_q && !core_clk_en_q && !issue_ready_q);
    endproperty
    a_wait: assert property (p_wait) else $error("wait hint not two");
endmodule

// >>> tb/itd_mem_model.sv
`timescale 1ns/1ps
module itd_mem_model
    import itd_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Observed issue handshake
    input wire logic issue_valid,
    input wire logic issue_ready_q,
    // Wait states for the next access, zero answers promptly
    input wire logic [3:0] wait_states,
    // To core
    output logic mem_wait
);
    logic [3:0] stall_q;

    // Stall counter armed on each take; slow memory stretches execution
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stall_q <= 4'h0;
        end else if (issue_valid && issue_ready_q) begin
            stall_q <= wait_states;
        end else if (stall_q != 4'h0) begin
            stall_q <= stall_q - 4'h1;
        end
    end

    assign mem_wait = (stall_q != 4'h0);
endmodule

// >>> tb/test_itd_core_timing.sv
`timescale 1ns/1ps
module test_itd_core_timing;
    import itd_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic issue_valid = 1'b0;
    itd_instr_t issue_instr = '0;
    logic issue_ready_q, mem_wait, retire_q, fault_q, wide_q, core_clk_en_q;
    logic wake_irq = 1'b0;
    logic [5:0] cycles_q;
    logic [3:0] wait_states = 4'h0;
    logic slow_valid = 1'b0;
    logic slow_ready_q, slow_retire_q;
    logic [5:0] slow_cycles_q;
    int errors = 0;
    int checks_done = 0;
    int cyc = 0;

    itd_core_timing itd_core_timing_inst (.clk(clk), .nrst(nrst), .issue_valid(issue_valid),
        .issue_instr(issue_instr), .issue_ready_q(issue_ready_q), .mem_wait(mem_wait),
        .wake_irq(wake_irq), .retire_q(retire_q), .cycles_q(cycles_q), .fault_q(fault_q),
        .wide_q(wide_q), .core_clk_en_q(core_clk_en_q));
    itd_mem_model itd_mem_model_inst (.clk(clk), .nrst(nrst), .issue_valid(issue_valid),
        .issue_ready_q(issue_ready_q), .wait_states(wait_states), .mem_wait(mem_wait));
    // Second core built with the iterative multiplier
    itd_core_timing #(.FAST_MUL(1'b0)) itd_core_timing_slow_inst (.clk(clk), .nrst(nrst),
        .issue_valid(slow_valid), .issue_instr(issue_instr), .issue_ready_q(slow_ready_q),
        .mem_wait(mem_wait), .wake_irq(wake_irq), .retire_q(slow_retire_q),
        .cycles_q(slow_cycles_q), .fault_q(), .wide_q(), .core_clk_en_q());

    initial begin
        forever #50 clk = ~clk;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic report_and_stop;
        if (errors == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Issue one instruction and time it from take to retire
    task automatic run(input logic [15:0] h0, input logic [15:0] h1, input logic c,
                       input logic [3:0] ws, input logic [5:0] n, input logic f);
        int k;
        logic w;
        w = (h0[15:11] == 5'h1D) || (h0[15:11] == 5'h1E) || (h0[15:11] == 5'h1F);
        k = 0;
        @(negedge clk);
        issue_valid = 1'b1;
        issue_instr = '{hw0: h0, hw1: h1, cond_pass: c};
        wait_states = ws;
        while (issue_ready_q !== 1'b1 && k < 50) begin
            @(negedge clk);
            k++;
        end
        @(negedge clk);
        issue_valid = 1'b0;
        issue_instr = {~h0, ~h1, ~c};
        wait_states = 4'h0;
        check("cycles", {26'h0, cycles_q}, {26'h0, n});
        check("fault", {31'h0, fault_q}, {31'h0, f});
        check("wide", {31'h0, wide_q}, {31'h0, w});
        check("busy", {31'h0, issue_ready_q}, 32'h0);
        k = 1;
        while (retire_q !== 1'b1 && k < 80) begin
            @(negedge clk);
            k++;
        end
        check("latency", k, n + ws + 1);
    endtask

    task automatic single_cycle_ops;
        logic [15:0] ops [13] = '{16'h2001, 16'h1888, 16'h0040, 16'h4159, 16'h4008, 16'hB200,
            16'hBA00, 16'hB001, 16'hA000, 16'hB672, 16'hB662, 16'hBF40, 16'hBF00};
        foreach (ops[i]) run(ops[i], 16'h0000, 1'b0, 4'h0, CYC_ONE, 1'b0);
        run(16'hBF10, 16'h0000, 1'b0, 4'h0, CYC_ONE, 1'b0);
        run(16'h4348, 16'h0000, 1'b0, 4'h0, CYC_ONE, 1'b0);
    endtask

    // Iterative multiplier build takes the long count
    task automatic slow_multiply;
        int k;
        @(negedge clk);
        issue_instr = '{hw0: 16'h4348, hw1: 16'h0000, cond_pass: 1'b0};
        slow_valid = 1'b1;
        @(negedge clk);
        slow_valid = 1'b0;
        check("slow_cycles", {26'h0, slow_cycles_q}, {26'h0, CYC_MUL_SLOW});
        check("slow_busy", {31'h0, slow_ready_q}, 32'h0);
        k = 1;
        while (slow_retire_q !== 1'b1 && k < 80) begin
            @(negedge clk);
            k++;
        end
        check("slow_latency", k, CYC_MUL_SLOW + 1);
    endtask

    task automatic flow_ops;
        run(16'h468F, 16'h0000, 1'b0, 4'h0, CYC_FLOW, 1'b0);
        run(16'h448F, 16'h0000, 1'b0, 4'h0, CYC_FLOW, 1'b0);
        run(16'hD0FE, 16'h0000, 1'b1, 4'h0, CYC_FLOW, 1'b0);
        run(16'hD0FE, 16'h0000, 1'b0, 4'h0, CYC_ONE, 1'b0);
        run(16'hE7FE, 16'h0000, 1'b0, 4'h0, CYC_FLOW, 1'b0);
        run(16'h4708, 16'h0000, 1'b0, 4'h0, CYC_FLOW, 1'b0);
        run(16'h4788, 16'h0000, 1'b0, 4'h0, CYC_FLOW, 1'b0);
        run(16'hF000, 16'hF800, 1'b0, 4'h0, CYC_FOUR, 1'b0);
    endtask

    task automatic memory_ops;
        run(16'h6800, 16'h0000, 1'b0, 4'h0, CYC_LDST, 1'b0);
        run(16'h5608, 16'h0000, 1'b0, 4'h0, CYC_LDST, 1'b0);
        run(16'h4800, 16'h0000, 1'b0, 4'h0, CYC_LDST, 1'b0);
        run(16'h9000, 16'h0000, 1'b0, 4'h0, CYC_LDST, 1'b0);
        // Word store with three memory wait states
        run(16'h6008, 16'h0000, 1'b0, 4'h3, CYC_LDST, 1'b0);
        run(16'hC806, 16'h0000, 1'b0, 4'h0, 6'h03, 1'b0);
        run(16'hB501, 16'h0000, 1'b0, 4'h0, 6'h03, 1'b0);
        run(16'hBC0F, 16'h0000, 1'b0, 4'h2, 6'h05, 1'b0);
        run(16'hBD01, 16'h0000, 1'b0, 4'h0, CYC_POP_PC_BASE + 6'h02, 1'b0);
    endtask

    task automatic system_ops;
        run(16'hF3EF, 16'h8000, 1'b0, 4'h0, CYC_FOUR, 1'b0);
        run(16'hF380, 16'h8808, 1'b0, 4'h0, CYC_FOUR, 1'b0);
        run(16'hF3BF, 16'h8F4F, 1'b0, 4'h0, CYC_FOUR, 1'b0);
        run(16'hF3BF, 16'h8F5F, 1'b0, 4'h0, CYC_FOUR, 1'b0);
        run(16'hF3BF, 16'h8F6F, 1'b0, 4'h0, CYC_FOUR, 1'b0);
        run(16'hDF00, 16'h0000, 1'b0, 4'h0, CYC_SVC, 1'b0);
        run(16'hBE00, 16'h0000, 1'b0, 4'h0, CYC_BREAKPOINT_OP, 1'b0);
    endtask

    task automatic undefined_ops;
        logic [15:0] bad [3] = '{16'hB100, 16'hB900, 16'hBF08};
        foreach (bad[i]) run(bad[i], 16'h0000, 1'b0, 4'h0, CYC_FAULT, 1'b1);
        run(16'hE92D, 16'h4000, 1'b0, 4'h0, CYC_FAULT, 1'b1);
    endtask

    // Both wait hints suspend until a wake arrives
    task automatic wait_hints;
        logic [15:0] hint [2] = '{16'hBF30, 16'hBF20};
        int k;
        foreach (hint[i]) begin
            run(hint[i], 16'h0000, 1'b0, 4'h0, CYC_HINT, 1'b0);
            repeat (3) @(negedge clk);
            check("clk_en", {31'h0, core_clk_en_q}, 32'h0);
            check("asleep", {31'h0, issue_ready_q}, 32'h0);
            wake_irq = 1'b1;
            k = 0;
            while (issue_ready_q !== 1'b1 && k < 8) begin
                @(negedge clk);
                k++;
            end
            wake_irq = 1'b0;
            check("woken", {31'h0, core_clk_en_q, issue_ready_q}, 32'h3);
        end
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            report_and_stop();
        end
    end

    initial begin
        repeat (5) @(negedge clk);
        check("rst", {26'h0, issue_ready_q, retire_q, cycles_q == 6'h00, fault_q, wide_q,
            core_clk_en_q}, {26'h0, 6'b101001});
        nrst = 1'b1;
        single_cycle_ops();
        slow_multiply();
        flow_ops();
        memory_ops();
        system_ops();
        undefined_ops();
        wait_hints();
        report_and_stop();
    end
endmodule
